// ==== irq_vec_pkg.sv ====
// constants and carrier types for the prioritised interrupt vectoring block
// assumes one 10 MHz clock; registers are read and written over io strobes at fixed addresses
package irq_vec_pkg;

	// ==========================================================
	// sources and vectors
	localparam int          NUM_SRC      = 12;
	localparam logic [3:0]  VEC_NONE     = 4'h0;
	localparam logic [15:0] RESET_ADDR   = 16'h0000;
	localparam int          VEC_SHIFT    = 1;          // two bytes per table entry

	// source bit positions (bit i is vector i+1)
	localparam int SRC_BUS_RESET = 0;
	localparam int SRC_HUB       = 8;
	localparam int EP_FIRST      = 3;
	localparam int NUM_EP        = 5;
	localparam int NUM_PORT      = 4;

	// ==========================================================
	// processor status and control view, and register addresses
	localparam logic [7:0] ADDR_PSC      = 8'hff;
	localparam logic [7:0] ADDR_VECTOR   = 8'h23;
	localparam logic [7:0] ADDR_GLB_EN   = 8'h20;
	localparam logic [7:0] ADDR_EP_EN    = 8'h21;
	localparam logic [7:0] ADDR_DEV_A    = 8'h10;
	localparam logic [7:0] ADDR_DEV_B    = 8'h40;
	localparam logic [7:0] ADDR_HUB_LO   = 8'h48;
	localparam logic [7:0] ADDR_HUB_HI   = 8'h51;
	localparam logic [7:0] ADDR_HUB_CTRL = 8'h4b;
	localparam int PSC_GIE_BIT   = 2;
	localparam int PSC_BRST_BIT  = 5;
	localparam int PSC_SENSE_BIT = 7;

	// ==========================================================
	// timing
	localparam int CLK_HZ       = 10_000_000;
	localparam int FAST_TICK_NS = 128_000;
	localparam int SLOW_TICK_NS = 1_024_000;
	localparam int SE0_MIN_NS   = 12_000;
	localparam int SE0_MAX_NS   = 16_000;
	localparam int FAST_CYC     = FAST_TICK_NS / (1_000_000_000 / CLK_HZ);
	localparam int SLOW_DIV     = SLOW_TICK_NS / FAST_TICK_NS;
	// detect once the lower bound is met, rounded up; stays inside the upper bound
	localparam int SE0_CYC      = (SE0_MIN_NS + (1_000_000_000 / CLK_HZ) - 1)
	                              / (1_000_000_000 / CLK_HZ);
	localparam int CALL_CYC     = 10;
	localparam int JUMP_CYC     = 5;

	// ==========================================================
	// carrier types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL = 2'b01,
		ST_JUMP = 2'b10
	} ack_state_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  vector;
		logic [15:0] addr;
		logic [15:0] ret_pc;
		logic        carry_flag;
		logic        zero_flag;
	} call_req_t;

	typedef struct packed {
		logic [NUM_PORT-1:0] conn_change;
		logic [NUM_PORT-1:0] babble;
		logic [NUM_PORT-1:0] resume;
		logic [NUM_PORT-1:0] port_en;
		logic [NUM_PORT-1:0] forced;
	} hub_evt_t;

endpackage

// ==== irq_vec.sv ====
// prioritised interrupt controller with vector call and bus reset detection
// assumes all inputs synchronous to mclk_i; the core asserts instr_done_i
// on the last cycle of every instruction and executes the pushed call
`timescale 1ns/10ps
// ==========================================================
module irq_vec
	import irq_vec_pkg::*;
(
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rstn_i,
	// core interface
	input  wire logic               instr_done_i,
	input  wire logic [15:0]        pc_i,
	input  wire logic               carry_flag_i,
	input  wire logic               zero_flag_i,
	input  wire logic               disable_irq_instruction_i,
	input  wire logic               enable_irq_instruction_i,
	input  wire logic               return_from_handler_instruction_i,
	input  wire logic               startup_delay_i,
	// register access strobes
	input  wire logic               io_rd_i,
	input  wire logic               io_wr_i,
	input  wire logic [7:0]         io_addr_i,
	input  wire logic [7:0]         io_wdata_i,
	// event sources
	input  wire logic               dp_i,
	input  wire logic               dm_i,
	input  wire logic [NUM_EP-1:0]  ep_in_host_ack_i,
	input  wire logic [NUM_EP-1:0]  ep_out_dev_ack_i,
	input  hub_evt_t                hub_evt_i,
	input  wire logic               dac_evt_i,
	input  wire logic               gpio_evt_i,
	input  wire logic               serial_evt_i,
	// outputs
	output call_req_t               call_o,
	output logic                    handler_start_o,
	output logic [7:0]              psc_o,
	output logic [7:0]              io_rdata_o,
	output logic [7:0]              glb_en_o,
	output logic [7:0]              ep_en_o,
	output logic                    regs_clear_o,
	output logic                    startup_abort_o,
	output logic                    restore_flags_o
);

	// ==========================================================
	// register state
	logic [NUM_SRC-1:0] pend_reg;
	logic               gie_reg;
	logic               brst_flag_reg;
	logic [7:0]         glb_en_reg;
	logic [7:0]         ep_en_reg;
	logic [7:0]         se0_cnt_reg;
	logic               se0_seen_reg;
	logic [10:0]        fast_cnt_reg;
	logic [3:0]         slow_cnt_reg;
	ack_state_t         state_reg;
	logic [3:0]         cyc_reg;

	// source enable per bit: endpoints from 0x21, others from 0x20
	// bus reset cannot be masked; bit 3 of the global enables is spare,
	// so hub, dac, gpio and serial take bits 4 to 7
	function automatic logic [NUM_SRC-1:0] src_en(input logic [7:0] g, input logic [7:0] e);
		src_en = {g[7:4], e[4:0], g[2:1], 1'b1};
	endfunction

	// fixed priority: lowest index wins
	function automatic logic [3:0] pick(input logic [NUM_SRC-1:0] p);
		pick = VEC_NONE;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				pick = 4'(i + 1);
			end
		end
	endfunction

	// ==========================================================
	// event formation
	wire logic                se0          = ~dp_i & ~dm_i;
	wire logic                se0_detect   = se0 && (se0_cnt_reg >= 8'(SE0_CYC));
	wire logic                brst_event   = se0_seen_reg & ~se0;
	wire logic                fast_tick    = fast_cnt_reg == 11'(FAST_CYC - 1);
	wire logic                slow_tick    = fast_tick && slow_cnt_reg == 4'(SLOW_DIV - 1);
	// an unacknowledged in never pulses host ack, so raises nothing
	wire logic [NUM_EP-1:0]   ep_evt       = ep_in_host_ack_i | ep_out_dev_ack_i;
	wire logic [NUM_PORT-1:0] hub_bits     = (hub_evt_i.conn_change & ~hub_evt_i.forced)
	                                       | ((hub_evt_i.babble | hub_evt_i.resume)
	                                          & hub_evt_i.port_en);
	wire logic [NUM_SRC-1:0]  events       = {serial_evt_i, gpio_evt_i, dac_evt_i, |hub_bits,
	                                          ep_evt, slow_tick, fast_tick, brst_event};
	wire logic [NUM_SRC-1:0]  enables      = src_en(glb_en_reg, ep_en_reg);
	wire logic [3:0]          winner       = pick(pend_reg);
	wire logic                vec_read     = io_rd_i && io_addr_i == ADDR_VECTOR;
	// take only at an instruction boundary and with global enable
	// a busy sequencer holds off a second accept until the jump is done
	wire logic                take         = gie_reg && instr_done_i && winner != VEC_NONE
	                                         && state_reg == ST_IDLE;
	wire logic [3:0]          clr_vec      = take ? winner : (vec_read ? winner : VEC_NONE);
	wire logic [7:0]          psc_next     = {|pend_reg, 1'b0, brst_flag_reg, 2'b00,
	                                          gie_reg, 2'b00};
	wire logic                wr_glb       = io_wr_i && io_addr_i == ADDR_GLB_EN;
	wire logic                wr_ep        = io_wr_i && io_addr_i == ADDR_EP_EN;
	wire logic                wr_psc       = io_wr_i && io_addr_i == ADDR_PSC;
	logic [7:0]               rdata_next;

	// read mux, address decode as an if chain
	always_comb begin
		if (io_addr_i == ADDR_PSC) begin
			rdata_next = psc_next;
		end else if (io_addr_i == ADDR_VECTOR) begin
			rdata_next = {4'h0, winner};
		end else if (io_addr_i == ADDR_GLB_EN) begin
			rdata_next = glb_en_reg;
		end else if (io_addr_i == ADDR_EP_EN) begin
			rdata_next = ep_en_reg;
		end else begin
			rdata_next = 8'h00;
		end
	end

	// ==========================================================
	// pending latches: event set wins over service clear
	// a vector read and an accept clear the same winner; neither drops a new event
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_pend
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pend_reg[gi] <= 1'b0;
				end else if (events[gi] && enables[gi]) begin
					pend_reg[gi] <= 1'b1;
				end else if (clr_vec == 4'(gi + 1)) begin
					pend_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// global enable: cleared on accept, only touched by di/ei/return
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gie_reg <= 1'b0;
		end else if (take || disable_irq_instruction_i) begin
			gie_reg <= 1'b0;
		end else if (enable_irq_instruction_i || return_from_handler_instruction_i) begin
			gie_reg <= 1'b1;
		end
	end

	// enable registers; bus reset leaves them alone
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			glb_en_reg <= 8'h00;
			ep_en_reg  <= 8'h00;
		end else begin
			if (wr_glb) begin
				glb_en_reg <= io_wdata_i;
			end
			if (wr_ep) begin
				ep_en_reg <= io_wdata_i;
			end
		end
	end

	// se0 duration counter; saturates so a long reset stays detected
	// counting stops at the threshold, so the counter never wraps
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			se0_cnt_reg  <= 8'h00;
			se0_seen_reg <= 1'b0;
		end else if (!se0) begin
			se0_cnt_reg  <= 8'h00;
			se0_seen_reg <= 1'b0;
		end else begin
			if (!se0_detect) begin
				se0_cnt_reg <= se0_cnt_reg + 8'h01;
			end
			se0_seen_reg <= se0_seen_reg | se0_detect;
		end
	end

	// bus reset flag: set by detection, cleared by writing zero at 0xff
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			brst_flag_reg <= 1'b0;
		end else if (se0_detect) begin
			brst_flag_reg <= 1'b1;
		end else if (wr_psc && !io_wdata_i[PSC_BRST_BIT]) begin
			brst_flag_reg <= 1'b0;
		end
	end

	// periodic tick divider; slow tick is every eighth fast tick
	// 1280 cycles per fast tick need eleven counter bits
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fast_cnt_reg <= 11'h000;
			slow_cnt_reg <= 4'h0;
		end else if (fast_tick) begin
			fast_cnt_reg <= 11'h000;
			slow_cnt_reg <= slow_tick ? 4'h0 : slow_cnt_reg + 4'h1;
		end else begin
			fast_cnt_reg <= fast_cnt_reg + 11'h001;
		end
	end

	// ==========================================================
	// acknowledge sequencer: call phase then table jump phase
	// the call phase counts ten cycles and the jump phase five
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			cyc_reg   <= 4'h0;
			// the call carries the reset fetch address until the first accept
			call_o    <= '{addr: RESET_ADDR, default: '0};
		end else begin
			call_o.valid <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						state_reg         <= ST_CALL;
						cyc_reg           <= 4'(CALL_CYC - 1);
						call_o.valid      <= 1'b1;
						call_o.vector     <= winner;
						call_o.addr       <= 16'(winner) << VEC_SHIFT;
						call_o.ret_pc     <= pc_i;
						call_o.carry_flag <= carry_flag_i;
						call_o.zero_flag  <= zero_flag_i;
					end
				end
				ST_CALL: begin
					if (cyc_reg == 4'h0) begin
						state_reg <= ST_JUMP;
						cyc_reg   <= 4'(JUMP_CYC - 1);
					end else begin
						cyc_reg <= cyc_reg - 4'h1;
					end
				end
				ST_JUMP: begin
					if (cyc_reg == 4'h0) begin
						state_reg <= ST_IDLE;
					end else begin
						cyc_reg <= cyc_reg - 4'h1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// registered outputs
	// status and read data lag their sources by one cycle
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			handler_start_o <= 1'b0;
			psc_o           <= 8'h00;
			io_rdata_o      <= 8'h00;
			glb_en_o        <= 8'h00;
			ep_en_o         <= 8'h00;
			regs_clear_o    <= 1'b0;
			startup_abort_o <= 1'b0;
			restore_flags_o <= 1'b0;
		end else begin
			handler_start_o <= state_reg == ST_JUMP && cyc_reg == 4'h0;
			psc_o           <= psc_next;
			io_rdata_o      <= rdata_next;
			glb_en_o        <= glb_en_reg;
			ep_en_o         <= ep_en_reg;
			regs_clear_o    <= se0_detect;
			startup_abort_o <= se0_detect && startup_delay_i;
			restore_flags_o <= return_from_handler_instruction_i;
		end
	end

endmodule

// ==== irq_vec_chk.sv ====
// checker: call vectoring, latency, return and bus reset timing
// assumes it is bound onto irq_vec, one clock domain
`timescale 1ns/10ps
module irq_vec_chk
	import irq_vec_pkg::*;
(
	// watched ports
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	input wire logic        instr_done_i,
	input wire logic [15:0] pc_i,
	input wire logic        carry_flag_i,
	input wire logic        zero_flag_i,
	input wire logic        return_from_handler_instruction_i,
	input wire logic        startup_delay_i,
	input wire logic        dp_i,
	input wire logic        dm_i,
	input call_req_t        call_o,
	input wire logic        handler_start_o,
	input wire logic [7:0]  psc_o,
	input wire logic        regs_clear_o,
	input wire logic        startup_abort_o,
	input wire logic        restore_flags_o
);
	// ====================
	// se0 run length, saturating so a long reset cannot wrap
	logic [7:0] se0_cnt_reg;
	wire        se0 = !dp_i && !dm_i;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			se0_cnt_reg <= 8'h00;
		else
			se0_cnt_reg <= !se0 ? 8'h00 : se0_cnt_reg + {7'h00, se0_cnt_reg != 8'hff};
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ====================
	// accept, call and return
	AST_CALL_ADDR: assert property (call_o.valid |-> call_o.addr ==
		{11'h000, call_o.vector, 1'b0} && call_o.vector inside {[4'h1:4'hc]}) else $error("bad call address");
	AST_CALL_STATE: assert property (call_o.valid |-> call_o.ret_pc == $past(pc_i) &&
		call_o.carry_flag == $past(carry_flag_i) && call_o.zero_flag == $past(zero_flag_i))
		else $error("pushed state differs from core state");
	AST_BOUNDARY: assert property (call_o.valid |-> $past(instr_done_i))
		else $error("call inside an instruction");
	AST_GIE_CLEAR: assert property (call_o.valid |=> !psc_o[PSC_GIE_BIT])
		else $error("global enable still set after accept");
	AST_LATENCY: assert property (call_o.valid |-> ##15 handler_start_o)
		else $error("handler start not 15 cycles after call");
	AST_RETURN: assert property (return_from_handler_instruction_i |=>
		restore_flags_o ##1 psc_o[PSC_GIE_BIT]) else $error("return did not restore");
	// ====================
	// bus reset; 0xaa = 170 cycles is past the mandatory bound
	AST_DETECT: assert property (se0_cnt_reg == 8'haa |->
		regs_clear_o && psc_o[PSC_BRST_BIT]) else $error("long se0 not detected");
	AST_BRST_REQ: assert property (se0_cnt_reg >= 8'haa ##1 !se0 |->
		##[1:4] psc_o[PSC_SENSE_BIT]) else $error("no request at se0 release");
	AST_ABORT: assert property (regs_clear_o && startup_delay_i |->
		##[0:2] startup_abort_o) else $error("start-up delay not aborted");
endmodule

// ==== core_model.sv ====
// core model: instructions of 1 to 4 cycles, fetch restarts at a called vector
// assumes call_i from irq_vec; pc and flags move at each instruction end
`timescale 1ns/10ps
module core_model
	import irq_vec_pkg::*;
(
	// clock, reset and call in
	input  wire logic   mclk_i,
	input  wire logic   rstn_i,
	input  call_req_t   call_i,
	// core state out
	output logic        instr_done_o,
	output logic [15:0] pc_o,
	output logic        carry_flag_o,
	output logic        zero_flag_o
);
	// ====================
	// cycles left; lengths vary so accept points wander
	logic [1:0] left_reg;
	assign instr_done_o = (left_reg == 2'h0);
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left_reg <= 2'h0;
			pc_o <= RESET_ADDR;
			{carry_flag_o, zero_flag_o} <= 2'h0;
		end else if (call_i.valid) begin
			left_reg <= 2'h3;
			pc_o <= call_i.addr;
		end else if (instr_done_o) begin
			left_reg <= pc_o[1:0];
			pc_o <= pc_o + 16'h0001;
			{carry_flag_o, zero_flag_o} <= pc_o[1:0];
		end else
			left_reg <= left_reg - 2'h1;
	end
endmodule

// ==== test_irq_vec.sv ====
// bench for irq_vec: request bursts, hub gating, timers, call path, bus reset
// assumes irq_vec_pkg, irq_vec, core_model and irq_vec_chk compiled before
`timescale 1ns/10ps
module test_irq_vec
	import irq_vec_pkg::*;
;
	// ====================
	// signals named as the ports
	logic              mclk_i, rstn_i, instr_done_i, carry_flag_i, zero_flag_i, dp_i, dm_i;
	logic              disable_irq_instruction_i, enable_irq_instruction_i, startup_delay_i;
	logic              return_from_handler_instruction_i, io_rd_i, io_wr_i, handler_start_o;
	logic              dac_evt_i, gpio_evt_i, serial_evt_i, regs_clear_o, startup_abort_o;
	logic              restore_flags_o;
	logic [15:0]       pc_i;
	logic [7:0]        io_addr_i, io_wdata_i, psc_o, io_rdata_o, glb_en_o, ep_en_o, q;
	logic [NUM_EP-1:0] ep_in_host_ack_i, ep_out_dev_ack_i;
	logic [11:0]       s;
	hub_evt_t          hub_evt_i;
	call_req_t         call_o;
	int                errors, n_compared, n;
	// hub event and levels, then expected vector
	logic [23:0]       hub_tab [6] = '{24'h100009, 24'h100010, 24'h020209, 24'h020100,
	                                   24'h004409, 24'h004000};
	irq_vec u_dut (.mclk_i, .rstn_i, .instr_done_i, .pc_i, .carry_flag_i, .zero_flag_i,
		.disable_irq_instruction_i, .enable_irq_instruction_i, .startup_delay_i,
		.return_from_handler_instruction_i, .io_rd_i, .io_wr_i, .io_addr_i, .io_wdata_i,
		.dp_i, .dm_i, .ep_in_host_ack_i, .ep_out_dev_ack_i, .hub_evt_i, .dac_evt_i,
		.gpio_evt_i, .serial_evt_i, .call_o, .handler_start_o, .psc_o, .io_rdata_o,
		.glb_en_o, .ep_en_o, .regs_clear_o, .startup_abort_o, .restore_flags_o);
	core_model u_core (.mclk_i, .rstn_i, .call_i(call_o), .instr_done_o(instr_done_i),
		.pc_o(pc_i), .carry_flag_o(carry_flag_i), .zero_flag_o(zero_flag_i));
	always #50 mclk_i = ~mclk_i;
	// ====================
	// tasks; everything is driven just after a rising edge
	task automatic end_sim();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// read data lands one cycle after the strobe
	task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		{io_rd_i, io_wr_i, io_addr_i, io_wdata_i} <= {!w, w, a, d};
		@(posedge mclk_i);
		{io_rd_i, io_wr_i} <= 2'h0;
		@(negedge mclk_i);
		q = io_rdata_o;
	endtask
	task automatic fire(input logic [11:0] m, input logic in_dir);
		@(posedge mclk_i);
		ep_in_host_ack_i <= in_dir ? m[7:3] : 5'h00;
		ep_out_dev_ack_i <= in_dir ? 5'h00 : m[7:3];
		hub_evt_i.conn_change <= {3'h0, m[8]};
		{serial_evt_i, gpio_evt_i, dac_evt_i} <= m[11:9];
		@(posedge mclk_i);
		{ep_in_host_ack_i, ep_out_dev_ack_i, hub_evt_i, serial_evt_i, gpio_evt_i, dac_evt_i} <= '0;
	endtask
	task automatic core_op(input logic [2:0] k);
		@(posedge mclk_i);
		{disable_irq_instruction_i, enable_irq_instruction_i, return_from_handler_instruction_i} <= k;
		@(posedge mclk_i);
		{disable_irq_instruction_i, enable_irq_instruction_i, return_from_handler_instruction_i} <= '0;
	endtask
	// bounded wait for a call (k) or for any pending request
	task automatic wait_hi(input int lim, input logic k);
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
			if (n > lim) begin
				errors++;
				$display("unexpected at %0t: wait ran out", $time);
				end_sim();
			end
		end while ((k ? call_o.valid : psc_o[PSC_SENSE_BIT]) !== 1'b1);
	endtask
	function automatic logic [15:0] first_vec(input logic [11:0] m);
		for (int i = 0; i < 12; i++) begin
			if (m[i])
				return 16'(i + 1);
		end
		return 16'h0000;
	endfunction
	// ====================
	// main sequence
	initial begin
		{mclk_i, rstn_i, startup_delay_i, io_rd_i, io_wr_i, dm_i, io_addr_i, io_wdata_i} = '0;
		{disable_irq_instruction_i, enable_irq_instruction_i, return_from_handler_instruction_i} = '0;
		{ep_in_host_ack_i, ep_out_dev_ack_i, hub_evt_i, serial_evt_i, gpio_evt_i, dac_evt_i} = '0;
		dp_i = 1'b1;
		{errors, n_compared} = '0;
		void'($urandom(71266));
		repeat (3) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(negedge mclk_i);
		chk(16'(psc_o), 16'h0000);
		io(1'b1, ADDR_GLB_EN, 8'hf8);
		io(1'b1, ADDR_EP_EN, 8'h00);
		fire(12'h0f8, 1'b1);
		io(1'b0, ADDR_VECTOR, 8'h00);
		chk(16'(q), 16'h0000);
		io(1'b1, ADDR_EP_EN, 8'h1f);
		io(1'b0, ADDR_GLB_EN, 8'h00);
		chk({q, ep_en_o}, 16'hf81f);
		chk(16'(glb_en_o), 16'h00f8);
		// random bursts drain lowest vector first, one per read
		repeat (30) begin
			s = 12'($urandom) & 12'hff8;
			fire(s, 1'($urandom));
			repeat (10) begin
				io(1'b0, ADDR_VECTOR, 8'h00);
				chk(16'(q), first_vec(s));
				if (s == 12'h000)
					break;
				s = s & (s - 12'h001);
			end
		end
		foreach (hub_tab[i]) begin
			@(posedge mclk_i);
			hub_evt_i <= hub_evt_t'(hub_tab[i][23:4]);
			@(posedge mclk_i);
			hub_evt_i <= '0;
			io(1'b0, ADDR_VECTOR, 8'h00);
			chk(16'(q), 16'(hub_tab[i][3:0]));
		end
		// timers: fast period 1280 cycles, then slow
		io(1'b1, ADDR_GLB_EN, 8'h02);
		wait_hi(1400, 1'b0);
		io(1'b0, ADDR_VECTOR, 8'h00);
		wait_hi(1400, 1'b0);
		chk({q, 7'h00, n inside {[1268:1282]}}, 16'h0201);
		io(1'b1, ADDR_GLB_EN, 8'h04);
		io(1'b0, ADDR_VECTOR, 8'h00);
		chk(16'(q), 16'h0002);
		wait_hi(10300, 1'b0);
		io(1'b0, ADDR_VECTOR, 8'h00);
		chk(16'(q), 16'h0003);
		io(1'b1, ADDR_GLB_EN, 8'hf8);
		// call path
		core_op(3'h2);
		fire(12'h400, 1'b0);
		wait_hi(60, 1'b1);
		chk({call_o.addr[11:0], call_o.vector}, 16'h016b);
		repeat (15) @(negedge mclk_i);
		chk({7'h00, handler_start_o, psc_o & 8'h84}, 16'h0100);
		core_op(3'h1);
		@(negedge mclk_i);
		chk(16'(restore_flags_o), 16'h0001);
		@(negedge mclk_i);
		chk(16'(psc_o[PSC_GIE_BIT]), 16'h0001);
		core_op(3'h4);
		repeat (2) @(negedge mclk_i);
		chk(16'(psc_o[PSC_GIE_BIT]), 16'h0000);
		// bus reset inside the start-up delay
		@(posedge mclk_i);
		{startup_delay_i, dp_i} <= 2'h2;
		repeat (150) @(posedge mclk_i);
		io(1'b0, ADDR_VECTOR, 8'h00);
		chk(16'(q), 16'h0000);
		repeat (20) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(16'({psc_o[PSC_BRST_BIT], regs_clear_o, startup_abort_o}), 16'h0007);
		@(posedge mclk_i);
		{startup_delay_i, dp_i} <= 2'h1;
		repeat (4) @(posedge mclk_i);
		io(1'b0, ADDR_VECTOR, 8'h00);
		chk(16'(q), 16'h0001);
		io(1'b1, ADDR_PSC, 8'h00);
		repeat (2) @(negedge mclk_i);
		chk(16'(psc_o[PSC_BRST_BIT]), 16'h0000);
		end_sim();
	end
endmodule
bind irq_vec irq_vec_chk u_chk (.mclk_i, .rstn_i, .instr_done_i, .pc_i, .carry_flag_i,
	.zero_flag_i, .return_from_handler_instruction_i, .startup_delay_i, .dp_i, .dm_i,
	.call_o, .handler_start_o, .psc_o, .regs_clear_o, .startup_abort_o, .restore_flags_o);
